// ==== src/spm_pkg.sv ====
// Constants, register map and state type of the SPI master/slave port.
// Assumes a single system clock; the APB offsets below are byte addresses.
`default_nettype none
package spm_pkg;
    // Register byte offsets on the APB slave
    localparam logic [11:0] SPM_MODE_OFS = 12'h000;
    localparam logic [11:0] SPM_FMT_OFS  = 12'h004;
    localparam logic [11:0] SPM_DATA_OFS = 12'h008;
    // Values after reset
    localparam logic [7:0]  SPM_MODE_RST = 8'he0;
    localparam logic [7:0]  SPM_FMT_RST  = 8'h00;
    localparam logic [7:0]  SPM_DATA_RST = 8'h00;
    // serial_mode_control fields
    localparam int          SPM_ROLE_LSB = 5;
    localparam int          SPM_UART_BIT = 4;
    localparam int          SPM_EN_BIT   = 1;
    localparam int          SPM_ICF_BIT  = 0;
    // spi_format_control fields
    localparam int          SPM_POL_BIT  = 5;
    localparam int          SPM_EDGE_BIT = 4;
    localparam int          SPM_MSB_BIT  = 3;
    localparam int          SPM_SELECT_PIN_ENABLE_BIT = 2;
    localparam int          SPM_WRITE_COLLISION_FLAG_BIT = 1;
    localparam int          SPM_TRF_BIT  = 0;
    // role_clock_select codes
    localparam logic [2:0]  SPM_ROLE_DIV4  = 3'h0;
    localparam logic [2:0]  SPM_ROLE_DIV16 = 3'h1;
    localparam logic [2:0]  SPM_ROLE_DIV64 = 3'h2;
    localparam logic [2:0]  SPM_ROLE_SUB   = 3'h3;
    localparam logic [2:0]  SPM_ROLE_TMR   = 3'h4;
    localparam logic [2:0]  SPM_ROLE_SLAVE = 3'h5;
    // Half-period masks of the serial clock divider (2, 8, 32 cycles)
    localparam logic [5:0]  SPM_HALF_DIV4  = 6'h01;
    localparam logic [5:0]  SPM_HALF_DIV16 = 6'h07;
    localparam logic [5:0]  SPM_HALF_DIV64 = 6'h1f;
    // Bits per byte and serial clock edges per master byte
    localparam logic [3:0]  SPM_BITS  = 4'h8;
    localparam logic [4:0]  SPM_EDGES = 5'h10;
    // System clock cycles of one master byte at the divide-by-4 rate
    localparam logic [5:0]  SPM_DIV4_RUN = 6'h20;
    typedef enum logic [0:0] {
        SPM_IDLE = 1'b0,
        SPM_RUN  = 1'b1
    } spm_state_type;
endpackage
`default_nettype wire

// ==== src/spm_port.sv ====
// SPI master/slave port with an APB register slave.
// Assumes pin inputs synchronous to CLOCK_I; output enables are active low.
`timescale 1ns/1ps
`default_nettype none
module spm_port
    import spm_pkg::*;
#(
    parameter int ADDR_W = 12
)(
    input  wire logic              CLOCK_I,
    input  wire logic              RESETN_I,
    input  wire logic              PSEL_I,
    input  wire logic              PENABLE_I,
    input  wire logic              PWRITE_I,
    input  wire logic [ADDR_W-1:0] PADDR_I,
    input  wire logic [31:0]       PWDATA_I,
    output logic      [31:0]       PRDATA_O,
    output logic                   PREADY_O,
    output logic                   PSLVERR_O,
    input  wire logic              SUB_TICK_I,
    input  wire logic              TMR_MATCH_I,
    input  wire logic              SCK_I,
    output logic                   SCK_O,
    output logic                   SCK_OE_N_O,
    input  wire logic              SDI_I,
    output logic                   SDO_O,
    output logic                   SDO_OE_N_O,
    input  wire logic              SCS_N_I,
    output logic                   SCS_N_O,
    output logic                   SCS_OE_N_O
);

    function automatic logic spm_half_tick(input logic [2:0] role, input logic [5:0] cnt,
                                           input logic sub, input logic tmr);
        case (role)
            SPM_ROLE_DIV4:  return (cnt & SPM_HALF_DIV4) == SPM_HALF_DIV4;
            SPM_ROLE_DIV16: return (cnt & SPM_HALF_DIV16) == SPM_HALF_DIV16;
            SPM_ROLE_DIV64: return (cnt & SPM_HALF_DIV64) == SPM_HALF_DIV64;
            SPM_ROLE_SUB:   return sub;
            SPM_ROLE_TMR:   return tmr;
            default:        return 1'b0;
        endcase
    endfunction

    logic [7:0]    mode_reg;
    logic [7:0]    fmt_reg;
    logic [7:0]    data_reg;
    logic [7:0]    shift_reg;
    logic [3:0]    cap_cnt;
    logic [4:0]    tog_cnt;
    logic [5:0]    div_cnt;
    logic          sck_in_d;
    logic          scs_in_d;
    spm_state_type state;
    spm_state_type next_state;

    // Field views
    wire [2:0] role     = mode_reg[SPM_ROLE_LSB +: 3];
    wire       iface_en = mode_reg[SPM_EN_BIT];
    wire       uart_sel = mode_reg[SPM_UART_BIT];
    wire       pol      = fmt_reg[SPM_POL_BIT];
    wire       cap_sel  = fmt_reg[SPM_EDGE_BIT];
    wire       msb_sel  = fmt_reg[SPM_MSB_BIT];
    wire       select_pin_enable     = fmt_reg[SPM_SELECT_PIN_ENABLE_BIT];

    wire spi_on    = iface_en && !uart_sel && role <= SPM_ROLE_SLAVE;
    wire is_master = spi_on && role < SPM_ROLE_SLAVE;
    wire is_slave  = spi_on && role == SPM_ROLE_SLAVE;
    wire idle_lvl  = ~pol;
    wire cap_rise  = (pol == cap_sel);
    wire sel_ok    = !select_pin_enable || !SCS_N_I;
    wire busy      = (state == SPM_RUN) || (cap_cnt != 4'h0);

    // APB decode; one wait state, then the access completes
    wire apb_acc  = PSEL_I && PENABLE_I && PREADY_O;
    wire apb_sel  = PSEL_I && PENABLE_I && !PREADY_O;
    wire hit_mode = PADDR_I[11:0] == SPM_MODE_OFS;
    wire hit_fmt  = PADDR_I[11:0] == SPM_FMT_OFS;
    wire hit_data = PADDR_I[11:0] == SPM_DATA_OFS;
    wire mapped   = hit_mode || hit_fmt || hit_data;
    wire wr_mode  = apb_acc && PWRITE_I && hit_mode;
    wire wr_fmt   = apb_acc && PWRITE_I && hit_fmt;
    wire wr_data  = apb_acc && PWRITE_I && hit_data;
    wire wr_ok    = wr_data && !busy;
    wire collide  = wr_data && busy;
    wire start    = wr_ok && is_master;
    wire [7:0] rd_mux = hit_mode ? mode_reg : hit_fmt ? fmt_reg : hit_data ? data_reg : 8'h00;

    // Serial edges: master from its divider, SUB_TICK_I or TMR_MATCH_I, slave from the sampled pin
    wire tick     = spm_half_tick(role, div_cnt, SUB_TICK_I, TMR_MATCH_I);
    // The first edge waits a cycle after start so data out leads it on the pin
    wire m_edge   = (state == SPM_RUN) && tick && (div_cnt != 6'h00 || tog_cnt != 5'h00);
    wire s_edge   = is_slave && sel_ok && (SCK_I != sck_in_d);
    wire new_lvl  = is_master ? ~SCK_O : SCK_I;
    wire is_cap   = (m_edge || s_edge) && (new_lvl == cap_rise);
    wire sdi_bit  = SDI_I;
    wire [7:0] next_shift = msb_sel ? {shift_reg[6:0], sdi_bit} : {sdi_bit, shift_reg[7:1]};
    wire out_bit  = msb_sel ? shift_reg[7] : shift_reg[0];
    wire byte_done = is_cap && (cap_cnt == SPM_BITS - 4'h1);
    wire inc_evt  = is_slave && select_pin_enable && SCS_N_I && !scs_in_d && (cap_cnt != 4'h0);
    // Software writing the incomplete flag never reaches this set term
    wire trf_set  = byte_done || inc_evt;
    wire last_tog = m_edge && (tog_cnt == SPM_EDGES - 5'h01);

    // Flags: a hardware set wins over a software write in the same cycle
    wire [7:0] next_mode = {wr_mode ? PWDATA_I[7:1] : mode_reg[7:1],
                            inc_evt | (wr_mode ? PWDATA_I[0] : mode_reg[0])};
    wire [7:0] next_fmt  = {wr_fmt ? PWDATA_I[7:2] : fmt_reg[7:2],
                            collide | (wr_fmt ? PWDATA_I[1] : fmt_reg[1]),
                            trf_set | (wr_fmt ? PWDATA_I[0] : fmt_reg[0])};

    wire next_sdo  = (busy || (is_slave && sel_ok)) ? out_bit : 1'b1;

    always_comb
    begin
        case (state)
            SPM_IDLE: next_state = start ? SPM_RUN : SPM_IDLE;
            SPM_RUN:  next_state = (!spi_on || last_tog) ? SPM_IDLE : SPM_RUN;
            default:  next_state = SPM_IDLE;
        endcase
    end

    // Control registers reset only here, never on an enable edge
    always_ff @(posedge CLOCK_I)
    begin
        if (!RESETN_I)
        begin
            mode_reg <= SPM_MODE_RST;
            fmt_reg  <= SPM_FMT_RST;
        end
        else
        begin
            mode_reg <= next_mode;
            fmt_reg  <= next_fmt;
        end
    end

    // Data register only loads the whole byte, so a read mid-byte shows the last one
    always_ff @(posedge CLOCK_I)
    begin
        if (!RESETN_I)
            data_reg <= SPM_DATA_RST;
        else if (byte_done && spi_on)
            data_reg <= next_shift;
        else if (wr_ok)
            data_reg <= PWDATA_I[7:0];
    end

    always_ff @(posedge CLOCK_I)
    begin
        if (!RESETN_I)
            shift_reg <= SPM_DATA_RST;
        else if (wr_ok)
            shift_reg <= PWDATA_I[7:0];
        else if (is_cap)
            shift_reg <= next_shift;
    end

    always_ff @(posedge CLOCK_I)
    begin
        if (!RESETN_I || !spi_on || inc_evt || byte_done)
            cap_cnt <= 4'h0;
        else if (is_cap)
            cap_cnt <= cap_cnt + 4'h1;
    end

    // Clocking runs from the system clock alone, so idle modes that keep it keep the port
    always_ff @(posedge CLOCK_I)
    begin
        if (!RESETN_I)
            state <= SPM_IDLE;
        else
            state <= next_state;
    end

    always_ff @(posedge CLOCK_I)
    begin
        if (!RESETN_I || start)
        begin
            tog_cnt <= 5'h00;
            div_cnt <= 6'h00;
        end
        else if (state == SPM_RUN)
        begin
            div_cnt <= div_cnt + 6'h01;
            tog_cnt <= m_edge ? tog_cnt + 5'h01 : tog_cnt;
        end
    end

    // Polarity changes while idle reach the pin a cycle after the register; mid-byte changes wait for the byte to end
    always_ff @(posedge CLOCK_I)
    begin
        if (!RESETN_I)
            SCK_O <= 1'b1;
        else if (state != SPM_RUN)
            SCK_O <= idle_lvl;
        else if (m_edge)
            SCK_O <= ~SCK_O;
    end

    always_ff @(posedge CLOCK_I)
    begin
        if (!RESETN_I)
        begin
            sck_in_d   <= 1'b0;
            scs_in_d   <= 1'b1;
            SDO_O      <= 1'b1;
            SDO_OE_N_O <= 1'b1;
            SCK_OE_N_O <= 1'b1;
            SCS_N_O    <= 1'b1;
            SCS_OE_N_O <= 1'b1;
        end
        else
        begin
            sck_in_d   <= SCK_I;
            scs_in_d   <= SCS_N_I;
            SDO_O      <= next_sdo;
            SDO_OE_N_O <= !spi_on;
            SCK_OE_N_O <= !is_master;
            // Select trails the last clock edge by a cycle so the slave still takes it
            SCS_N_O    <= next_state != SPM_RUN && state != SPM_RUN;
            SCS_OE_N_O <= !(is_master && select_pin_enable);
        end
    end

    always_ff @(posedge CLOCK_I)
    begin
        if (!RESETN_I)
        begin
            PREADY_O  <= 1'b0;
            PRDATA_O  <= 32'h0000_0000;
            PSLVERR_O <= 1'b0;
        end
        else
        begin
            PREADY_O  <= apb_sel;
            PRDATA_O  <= (apb_sel && !PWRITE_I) ? {24'h00_0000, rd_mux} : 32'h0000_0000;
            PSLVERR_O <= apb_sel && !mapped;
        end
    end

    // Helper for checking the length of a master byte
    logic [5:0] run_len;
    always_ff @(posedge CLOCK_I)
    begin
        if (!RESETN_I || start)
            run_len <= 6'h00;
        else if (state == SPM_RUN)
            run_len <= run_len + 6'h01;
    end

    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RESETN_I);

    property p_collision;
        collide |=> fmt_reg[SPM_WRITE_COLLISION_FLAG_BIT] && data_reg == $past(data_reg);
    endproperty
    a_collision: assert property (p_collision) else $error("write during transfer not refused");

    property p_write_collision_flag_hold;
        fmt_reg[SPM_WRITE_COLLISION_FLAG_BIT] && !wr_fmt |=> fmt_reg[SPM_WRITE_COLLISION_FLAG_BIT];
    endproperty
    a_write_collision_flag_hold: assert property (p_write_collision_flag_hold) else $error("collision flag lost");

    property p_trf_end;
        byte_done && spi_on |=> fmt_reg[SPM_TRF_BIT] && data_reg == $past(next_shift);
    endproperty
    a_trf_end: assert property (p_trf_end) else $error("byte end not flagged");

    property p_incomplete;
        inc_evt |=> mode_reg[SPM_ICF_BIT] && fmt_reg[SPM_TRF_BIT] && cap_cnt == 4'h0;
    endproperty
    a_incomplete: assert property (p_incomplete) else $error("incomplete not flagged");

    property p_start;
        start |=> state == SPM_RUN ##1 SCK_O == $past(SCK_O, 2);
    endproperty
    a_start: assert property (p_start) else $error("master did not start");

    property p_div4_len;
        $fell(state == SPM_RUN) && role == SPM_ROLE_DIV4 && spi_on |-> run_len == SPM_DIV4_RUN;
    endproperty
    a_div4_len: assert property (p_div4_len) else $error("master byte length wrong");

    property p_hold_data;
        cap_cnt != 4'h0 && !byte_done && !inc_evt |=> $stable(data_reg);
    endproperty
    a_hold_data: assert property (p_hold_data) else $error("data register changed mid-byte");

    property p_disabled;
        !iface_en |=> SDO_OE_N_O && SCK_OE_N_O && SCS_OE_N_O;
    endproperty
    a_disabled: assert property (p_disabled) else $error("pins driven while disabled");

    property p_sck_idle;
        is_master && state == SPM_IDLE ##1 is_master && state == SPM_IDLE |-> SCK_O == ~$past(pol);
    endproperty
    a_sck_idle: assert property (p_sck_idle) else $error("clock not at idle level");

    property p_sdo_idle;
        is_master && !busy |=> SDO_O;
    endproperty
    a_sdo_idle: assert property (p_sdo_idle) else $error("data out not high when idle");

    property p_scs_lead;
        start |=> !SCS_N_O;
    endproperty
    a_scs_lead: assert property (p_scs_lead) else $error("select not low at start");

    property p_scs_trail;
        $fell(state == SPM_RUN) && !start |-> !SCS_N_O ##1 SCS_N_O;
    endproperty
    a_scs_trail: assert property (p_scs_trail) else $error("select released too early");

    property p_sck_drive;
        is_master |=> !SCK_OE_N_O;
    endproperty
    a_sck_drive: assert property (p_sck_drive) else $error("master clock not driven");

    property p_uart_off;
        uart_sel |=> SDO_OE_N_O && SCK_OE_N_O && SCS_OE_N_O;
    endproperty
    a_uart_off: assert property (p_uart_off) else $error("pins driven in uart mode");

    property p_select_pin_enable_off;
        !select_pin_enable |=> SCS_OE_N_O;
    endproperty
    a_select_pin_enable_off: assert property (p_select_pin_enable_off) else $error("select driven while disabled");

    property p_sw_icf;
        wr_mode && PWDATA_I[SPM_ICF_BIT] && !wr_fmt && !trf_set |=> $stable(fmt_reg[SPM_TRF_BIT]);
    endproperty
    a_sw_icf: assert property (p_sw_icf) else $error("software incomplete set complete");

    property p_fmt_store;
        wr_fmt |=> fmt_reg[7:6] == $past(PWDATA_I[7:6]);
    endproperty
    a_fmt_store: assert property (p_fmt_store) else $error("storage bits not kept");

    c_master_byte: cover property (start ##[1:600] byte_done);
    c_slave_byte:  cover property (is_slave && byte_done);
    c_incomplete:  cover property (inc_evt);
    c_collision:   cover property (collide);
    c_sw_icf:      cover property (wr_mode && PWDATA_I[SPM_ICF_BIT] && !mode_reg[SPM_ICF_BIT]);

endmodule
`default_nettype wire

// ==== testbench/spm_slave_model.sv ====
// SPI slave model that faces the port while it runs as master.
// Assumes SCK and SDO come from flops on clk_i and select enable is set.
`timescale 1ns/1ps
`default_nettype none
module spm_slave_model (
    input  wire logic       clk_i,
    input  wire logic       sck_i,
    input  wire logic       sdo_i,
    input  wire logic       scs_n_i,
    input  wire logic [2:0] cfg_i,
    input  wire logic [7:0] tx_i,
    output logic            sdi_o,
    output logic [7:0]      rx_o
);
    logic       sck_q;
    logic       sdo_q;
    logic       last;
    logic [3:0] cnt;
    wire        cap_lvl = cfg_i[2] == cfg_i[1];
    wire        cap     = sck_i != sck_q && sck_i == cap_lvl;
    wire  [2:0] idx     = cfg_i[0] ? 3'h7 - cnt[2:0] : cnt[2:0];
    // Past the eighth bit the line is not held, so it shows the inverse
    assign sdi_o = cnt < 4'h8 ? tx_i[idx] : ~last;
    always @(posedge clk_i)
    begin
        sck_q <= sck_i;
        sdo_q <= sdo_i;
        if (scs_n_i)
            cnt <= 4'h0;
        else if (cap && cnt < 4'h8)
        begin
            // SDO may move with the capture edge, so the older sample is used
            rx_o <= cfg_i[0] ? {rx_o[6:0], sdo_q} : {sdo_q, rx_o[7:1]};
            last <= sdi_o;
            cnt  <= cnt + 4'h1;
        end
    end
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
// Self-checking bench of the SPI port: APB master, slave model, slave driver.
// Assumes the port answers APB in its own time; every wait is bounded.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import spm_pkg::*;
    logic        clk    = 1'b0;
    logic        rstn   = 1'b0;
    logic        psel   = 1'b0;
    logic        pen    = 1'b0;
    logic        pwr    = 1'b0;
    logic [11:0] paddr  = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic        sck_s  = 1'b1;
    logic        sdi_s  = 1'b0;
    logic        scs_s  = 1'b1;
    logic        smode  = 1'b0;
    logic [2:0]  cfg    = 3'h0;
    logic [7:0]  ptx    = 8'h00;
    logic        stick  = 1'b0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        sck_o;
    logic        sck_oe_n;
    logic        sdo_o;
    logic        sdo_oe_n;
    logic        scs_n_o;
    logic        scs_oe_n;
    logic        p_sdi;
    logic [7:0]  prx;
    logic [31:0] rd;
    logic        err;
    int          num_errors = 0;
    int          n_compared = 0;
    always #20 clk = ~clk;
    // Sub clock and timer match pulses on every other cycle
    always @(posedge clk) stick <= ~stick;
    spm_port DUT (
        .CLOCK_I(clk), .RESETN_I(rstn), .PSEL_I(psel), .PENABLE_I(pen),
        .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .SUB_TICK_I(stick),
        .TMR_MATCH_I(stick), .SCK_I(sck_s), .SCK_O(sck_o), .SCK_OE_N_O(sck_oe_n),
        .SDI_I(smode ? sdi_s : p_sdi), .SDO_O(sdo_o), .SDO_OE_N_O(sdo_oe_n),
        .SCS_N_I(scs_s), .SCS_N_O(scs_n_o), .SCS_OE_N_O(scs_oe_n)
    );
    spm_slave_model PEER (
        .clk_i(clk), .sck_i(sck_o), .sdo_i(sdo_o), .scs_n_i(scs_n_o),
        .cfg_i(cfg), .tx_i(ptx), .sdi_o(p_sdi), .rx_o(prx)
    );
    task automatic summarize();
        $display("Compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic tmo();
        num_errors++;
        $display("Error wait expected done seen timeout");
        summarize();
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            $display("Error %s expected %h seen %h", nm, e, g);
            num_errors++;
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        int i;
        psel   <= 1'b1;
        pwr    <= w;
        paddr  <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        pen <= 1'b1;
        i = 0;
        do
        begin
            @(posedge clk);
            i++;
        end
        while (pready !== 1'b1 && i < 20);
        if (i >= 20)
            tmo();
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen  <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [7:0] e, input string nm);
        apb(1'b0, a, 8'h00);
        chk(nm, {24'h0, e}, rd);
    endtask
    task automatic wait_done();
        int i;
        i = 0;
        do
        begin
            apb(1'b0, SPM_FMT_OFS, 8'h00);
            i++;
        end
        while (rd[SPM_TRF_BIT] !== 1'b1 && i < 100);
        if (i >= 100)
            tmo();
    endtask
    task automatic mxfer(input logic [7:0] m, input logic [7:0] f, input logic [7:0] tx,
                         input logic [7:0] px);
        ptx <= px;
        cfg <= f[5:3];
        apb(1'b1, SPM_MODE_OFS, m);
        apb(1'b1, SPM_FMT_OFS, f);
        cyc(2);
        chk("sck idle", {31'h0, ~f[5]}, 32'(sck_o));
        chk("scs idle", 32'h1, 32'(scs_n_o));
        apb(1'b1, SPM_DATA_OFS, tx);
        chk("scs run", 32'h0, 32'(scs_n_o));
        apb(1'b1, SPM_DATA_OFS, ~tx);
        wait_done();
        chk("fmt flags", {24'h0, f | 8'h03}, rd);
        rdchk(SPM_DATA_OFS, px, "rx byte");
        chk("peer byte", {24'h0, tx}, {24'h0, prx});
        apb(1'b1, SPM_FMT_OFS, f);
        rdchk(SPM_FMT_OFS, f, "fmt clear");
    endtask
    task automatic sclk(input logic [7:0] tx, input logic [7:0] rx, input int n);
        for (int i = 0; i < n; i++)
        begin
            sck_s <= 1'b0;
            sdi_s <= rx[7 - i];
            cyc(6);
            chk("slave sdo", 32'(tx[7 - i]), 32'(sdo_o));
            sck_s <= 1'b1;
            cyc(6);
        end
    endtask
    initial
    begin
        cyc(2);
        rstn <= 1'b1;
        chk("oe idle", 32'h7, {29'h0, sck_oe_n, sdo_oe_n, scs_oe_n});
        rdchk(SPM_MODE_OFS, SPM_MODE_RST, "mode rst");
        rdchk(SPM_FMT_OFS, 8'h00, "fmt rst");
        apb(1'b0, 12'h00c, 8'h00);
        chk("unmapped", 32'h1, 32'(err));
        apb(1'b1, SPM_FMT_OFS, 8'hc4);
        apb(1'b1, SPM_MODE_OFS, 8'h02);
        rdchk(SPM_FMT_OFS, 8'hc4, "fmt kept");
        cyc(2);
        chk("sdo high", 32'h1, 32'(sdo_o));
        chk("scs oe", 32'h0, 32'(scs_oe_n));
        for (int r = 0; r < 8; r++)
        begin
            apb(1'b1, SPM_MODE_OFS, {r[2:0], 5'h02});
            cyc(2);
            rdchk(SPM_MODE_OFS, {r[2:0], 5'h02}, "mode");
            chk("sck oe", 32'(r > 4), 32'(sck_oe_n));
            chk("sdo oe", 32'(r > 5), 32'(sdo_oe_n));
        end
        apb(1'b1, SPM_MODE_OFS, 8'h12);
        cyc(2);
        chk("uart oe", 32'h1, 32'(sdo_oe_n));
        mxfer(8'h02, 8'h0c, 8'ha5, 8'h3c);
        mxfer(8'h02, 8'h14, 8'hc1, 8'h0f);
        mxfer(8'h02, 8'h2c, 8'h96, 8'h71);
        mxfer(8'h22, 8'h34, 8'h5a, 8'he8);
        mxfer(8'h62, 8'h14, 8'h3e, 8'hd2);
        mxfer(8'h82, 8'h2c, 8'h81, 8'h7e);
        apb(1'b1, SPM_MODE_OFS, 8'ha2);
        apb(1'b1, SPM_FMT_OFS, 8'h0c);
        apb(1'b1, SPM_DATA_OFS, 8'h96);
        smode <= 1'b1;
        scs_s <= 1'b0;
        cyc(4);
        sclk(8'h96, 8'h5b, 8);
        scs_s <= 1'b1;
        cyc(4);
        rdchk(SPM_DATA_OFS, 8'h5b, "slave rx");
        rdchk(SPM_FMT_OFS, 8'h0d, "slave done");
        rdchk(SPM_MODE_OFS, 8'ha2, "no icf");
        apb(1'b1, SPM_FMT_OFS, 8'h0c);
        apb(1'b1, SPM_DATA_OFS, 8'h3c);
        scs_s <= 1'b0;
        cyc(4);
        sclk(8'h3c, 8'hff, 3);
        scs_s <= 1'b1;
        cyc(4);
        rdchk(SPM_MODE_OFS, 8'ha3, "icf set");
        rdchk(SPM_FMT_OFS, 8'h0d, "icf trf");
        apb(1'b1, SPM_FMT_OFS, 8'h0c);
        apb(1'b1, SPM_MODE_OFS, 8'ha2);
        apb(1'b1, SPM_MODE_OFS, 8'ha3);
        rdchk(SPM_FMT_OFS, 8'h0c, "sw icf");
        summarize();
    end
endmodule
`default_nettype wire
